/* File: hw/lpm_payload_mapper.sv */
`timescale 1ns/1ps
// Functional notes
// - Lane select: low three lanes, high four
// - Three lanes: no lane four, control1, control2
// - Audio disabled: audio data pin becomes control0
// - Pixel clock span depends on lane mode
// - Only recovered, decoded, descrambled words are used
// - Twenty-one or twenty-eight payload bits per word
// - Four lanes: bits 27, 28 drive controls
// - Extract audio carrier and forward control bits
// - Last bit is parity over preceding bits
// - Colour, sync and valid bit positions fixed
// - Bit 27 drives spare and control1 outputs
// - D2 forces spare low, D3 control1 low
// - Range select high picks the low range
// - Audio words buffered, rate measured, played I2S
// - I2S covers 8-192 kHz, 4-32 bit words
// - Audio path active after reset
// - Low pixel clocks limit audio sample rate
// - Spread spectrum never alters I2S rates
// - Zero divider: control2 pin; nonzero: master clock
// - Master clock is source over divider 1-127
// - Source bit zero, high speed: 3x or 4x
// - Low speed 6x or 8x; bit set: oscillator
// - Master clock ignores local spread spectrum
// - Oscillator runs between 100 and 150 MHz
module lpm_payload_mapper
  import lpm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Decoded word stream from the link front end
  input  wire logic [31:0] decodedWord,
  input  wire logic        decodedWordValid,
  // Strap and mode inputs
  input  wire logic        laneWidthSelect,
  input  wire logic        clockRangeSelect,
  input  wire logic        audioEnable,
  input  wire logic [5:0]  audioWordLength,
  // Divider source ticks
  input  wire logic        pixelSourceTick,
  input  wire logic        oscillatorTick,
  // Register access from the control channel
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic [7:0]       regRdData,
  // LVDS lane payload
  output logic [27:0]      lanePayload,
  output logic             fourthLvdsLaneEn,
  output logic             clockRangeLow,
  output logic [3:0]       sourceMultiple,
  // Auxiliary controls
  output logic             spareBitOutput,
  output logic             auxControlOne,
  output logic             auxControlOneEn,
  output logic             control2OrAudioClock,
  output logic             control2OrAudioClockEn,
  output logic             forwardControlBit,
  // Audio outputs
  output logic             audioDataOrControl0,
  output logic             i2sBitClock,
  output logic             i2sWordSelect,
  // Status
  output logic [7:0]       parityErrorCount,
  output logic             audioOverflow
);

  // Reset release through two flops; assertion is immediate
  logic rstSync1_reg;
  logic rstn;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1_reg <= 1'b0;
      rstn         <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstn         <= rstSync1_reg;
    end
  end

  // Even parity over the low n bits
  function automatic logic parity_of(input logic [31:0] w, input logic fourLane);
    parity_of = fourLane ? ^w[30:0] : ^w[22:0];
  endfunction

  // Register file
  logic [7:0] clkDivCtrl_reg;
  logic [7:0] outputConfig_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkDivCtrl_reg   <= CLK_DIV_CTRL_RESET;
      outputConfig_reg <= OUTPUT_CONFIG_RESET;
    end else if (regWrEn) begin
      if (regAddr == CLK_DIV_CTRL_ADDR) clkDivCtrl_reg <= regWrData;
      if (regAddr == OUTPUT_CONFIG_ADDR) outputConfig_reg <= regWrData;
    end
  end

  // Read decode; unmapped addresses read zero
  wire logic [7:0] rdDecode = (regAddr == CLK_DIV_CTRL_ADDR) ? clkDivCtrl_reg :
                              (regAddr == OUTPUT_CONFIG_ADDR) ? outputConfig_reg : 8'h00;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) regRdData <= 8'h00;
    else       regRdData <= rdDecode;
  end

  // Field decode
  wire logic       fourLane     = laneWidthSelect;
  wire logic [6:0] masterDiv    = clkDivCtrl_reg[6:0];
  wire logic       srcIsOsc     = clkDivCtrl_reg[DIV_SRC_BIT];
  wire logic       spareLow     = outputConfig_reg[SPARE_LOW_BIT];
  wire logic       ctrl1Low     = outputConfig_reg[CTRL1_LOW_BIT];
  wire logic       mclkActive   = (masterDiv != 7'h00);

  // Word field extraction; the front end has already recovered and decoded
  wire logic       carrierBit = fourLane ? decodedWord[CARRIER4_POS]
                                         : decodedWord[CARRIER3_POS];
  wire logic       fwdCtlBit  = fourLane ? decodedWord[FWDCTL4_POS]
                                         : decodedWord[FWDCTL3_POS];
  wire logic       parityBit  = fourLane ? decodedWord[PARITY4_POS]
                                         : decodedWord[PARITY3_POS];
  wire logic       parityBad  = parity_of(decodedWord, fourLane) != parityBit;
  wire logic [27:0] payloadSel = fourLane ? decodedWord[27:0]
                                          : {7'h00, decodedWord[20:0]};

  // Source multiple follows lane and range mode
  wire logic [3:0] multSel = srcIsOsc ? MULT_OSC :
                             clockRangeSelect ? (fourLane ? MULT_LS_4LANE : MULT_LS_3LANE) :
                             (fourLane ? MULT_HS_4LANE : MULT_HS_3LANE);

  // Lane payload and forwarded control bit, updated once per accepted word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lanePayload       <= 28'h000_0000;
      forwardControlBit <= 1'b0;
    end else if (decodedWordValid) begin
      lanePayload       <= payloadSel;
      forwardControlBit <= fwdCtlBit;
    end
  end

  // Mode outputs; the lvds clock generator picks its range from these
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fourthLvdsLaneEn       <= 1'b0;
      auxControlOneEn        <= 1'b0;
      control2OrAudioClockEn <= 1'b0;
      clockRangeLow          <= 1'b0;
      sourceMultiple         <= MULT_HS_3LANE;
    end else begin
      fourthLvdsLaneEn       <= fourLane;
      auxControlOneEn        <= fourLane;
      control2OrAudioClockEn <= fourLane;
      clockRangeLow          <= clockRangeSelect;
      sourceMultiple         <= multSel;
    end
  end

  // Bit 27 of the newest word, or the held copy, so a force bit acts at once
  wire logic       bit27Now = decodedWordValid ? decodedWord[AUX1_POS] : lanePayload[AUX1_POS];

  // Spare and control1 outputs from bit 27; force bits win over payload
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spareBitOutput <= 1'b0;
      auxControlOne  <= 1'b0;
    end else if (!fourLane) begin
      spareBitOutput <= 1'b0;
      auxControlOne  <= 1'b0;
    end else begin
      spareBitOutput <= bit27Now & ~spareLow;
      auxControlOne  <= bit27Now & ~ctrl1Low;
    end
  end

  // Parity error counter saturates rather than wrapping
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) parityErrorCount <= 8'h00;
    else if (decodedWordValid && parityBad && parityErrorCount != 8'hFF)
      parityErrorCount <= parityErrorCount + 8'h01;
  end

  // Master clock divider; ticks come from the multiplied pixel clock or oscillator,
  // so local spread spectrum never enters the count
  wire logic       srcTick = srcIsOsc ? oscillatorTick : pixelSourceTick;
  logic [6:0] divCnt_reg;
  logic       mclk_reg;
  wire logic [6:0] divCntNext = (divCnt_reg >= masterDiv - 7'h01) ? 7'h00
                                                                  : divCnt_reg + 7'h01;
  wire logic [6:0] divHalf    = 7'((8'(masterDiv) + 8'h01) >> 1);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_reg <= 7'h00;
      mclk_reg   <= 1'b0;
    end else if (!mclkActive) begin
      // Park at the top so the first tick opens a high phase
      divCnt_reg <= 7'h7F;
      mclk_reg   <= 1'b0;
    end else if (masterDiv == 7'h01) begin
      mclk_reg   <= srcTick;
    end else if (srcTick) begin
      divCnt_reg <= divCntNext;
      mclk_reg   <= (divCntNext < divHalf);
    end
  end

  // Shared control2 pin: divided clock or bit 28
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) control2OrAudioClock <= 1'b0;
    else if (!fourLane) control2OrAudioClock <= 1'b0;
    else if (mclkActive) control2OrAudioClock <= mclk_reg;
    else if (decodedWordValid) control2OrAudioClock <= decodedWord[AUX2_POS];
  end

  // Audio rate measurement: cycles between words set the playout bit period,
  // so playout tracks arrival and spread spectrum changes nothing
  logic [15:0] wordGap_reg;
  logic [15:0] bitPeriod_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wordGap_reg   <= 16'h0000;
      bitPeriod_reg <= BIT_PERIOD_MIN;
    end else if (decodedWordValid) begin
      wordGap_reg   <= 16'h0000;
      bitPeriod_reg <= (wordGap_reg + 16'h0001 < BIT_PERIOD_MIN) ? BIT_PERIOD_MIN
                                                                 : wordGap_reg + 16'h0001;
    end else if (wordGap_reg != 16'hFFFF) begin
      wordGap_reg   <= wordGap_reg + 16'h0001;
    end
  end

  // Clamp word length to the supported span
  wire logic [5:0] wordLen = (audioWordLength < WORD_LEN_MIN) ? WORD_LEN_MIN :
                             (audioWordLength > WORD_LEN_MAX) ? WORD_LEN_MAX :
                             audioWordLength;

  // Carrier bit deserialiser, MSB first
  logic [31:0] collect_reg;
  logic [5:0]  collectCnt_reg;
  wire logic   collectDone = decodedWordValid && audioEnable &&
                             (collectCnt_reg == wordLen - 6'h01);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      collect_reg    <= 32'h0000_0000;
      collectCnt_reg <= 6'h00;
    end else if (!audioEnable) begin
      collectCnt_reg <= 6'h00;
    end else if (decodedWordValid) begin
      collect_reg    <= {collect_reg[30:0], carrierBit};
      collectCnt_reg <= collectDone ? 6'h00 : collectCnt_reg + 6'h01;
    end
  end

  // Audio word FIFO; depth of several words absorbs rate jitter
  logic [31:0]        fifoMem_reg [FIFO_DEPTH];
  logic [FIFO_AW:0]   wrPtr_reg;
  logic [FIFO_AW:0]   rdPtr_reg;
  wire logic [FIFO_AW:0] fifoLevel = wrPtr_reg - rdPtr_reg;
  wire logic          fifoFull  = (fifoLevel == (FIFO_AW+1)'(FIFO_DEPTH));
  wire logic          fifoEmpty = (fifoLevel == '0);
  wire logic [31:0]   pushWord  = {collect_reg[30:0], carrierBit} << (6'd32 - wordLen);
  logic               popReq;
  wire logic          doPush    = collectDone && !fifoFull;
  wire logic          doPop     = popReq && !fifoEmpty;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg     <= '0;
      rdPtr_reg     <= '0;
      audioOverflow <= 1'b0;
    end else begin
      if (doPush) wrPtr_reg <= wrPtr_reg + 1'b1;
      if (doPop)  rdPtr_reg <= rdPtr_reg + 1'b1;
      audioOverflow <= collectDone && fifoFull;
    end
  end
  always_ff @(posedge clk) begin
    if (doPush) fifoMem_reg[wrPtr_reg[FIFO_AW-1:0]] <= pushWord;
  end

  // I2S player: word select flips at the end of the last bit, together with the next word's first bit
  lpm_play_t   playState_reg;
  logic [15:0] bitTimer_reg;
  logic [31:0] shift_reg;
  logic [5:0]  bitIdx_reg;
  wire logic   bitEnd  = (bitTimer_reg == bitPeriod_reg - 16'h0001);
  // Rise one cycle before mid-bit so even the shortest period shows a pulse
  wire logic   halfHit = (bitTimer_reg == (bitPeriod_reg >> 1) - 16'h0001);
  wire logic   lastBit = (bitIdx_reg == wordLen - 6'h01);
  assign popReq = (playState_reg == LPM_IDLE) || (bitEnd && lastBit);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      playState_reg <= LPM_IDLE;
      bitTimer_reg  <= 16'h0000;
      shift_reg     <= 32'h0000_0000;
      bitIdx_reg    <= 6'h00;
      i2sBitClock   <= 1'b0;
      i2sWordSelect <= 1'b0;
    end else if (!audioEnable) begin
      playState_reg <= LPM_IDLE;
      i2sBitClock   <= 1'b0;
      i2sWordSelect <= 1'b0;
    end else begin
      case (playState_reg)
        LPM_IDLE: begin
          bitTimer_reg <= 16'h0000;
          bitIdx_reg   <= 6'h00;
          if (!fifoEmpty) begin
            shift_reg     <= fifoMem_reg[rdPtr_reg[FIFO_AW-1:0]];
            playState_reg <= LPM_PLAY;
          end
        end
        LPM_PLAY: begin
          bitTimer_reg <= bitEnd ? 16'h0000 : bitTimer_reg + 16'h0001;
          if (halfHit) i2sBitClock <= 1'b1;
          if (bitEnd) begin
            i2sBitClock <= 1'b0;
            if (lastBit) begin
              i2sWordSelect <= ~i2sWordSelect;
              bitIdx_reg    <= 6'h00;
              shift_reg     <= fifoEmpty ? 32'h0000_0000
                                         : fifoMem_reg[rdPtr_reg[FIFO_AW-1:0]];
            end else begin
              bitIdx_reg <= bitIdx_reg + 6'h01;
              shift_reg  <= {shift_reg[30:0], 1'b0};
            end
          end
        end
        default: playState_reg <= LPM_IDLE;
      endcase
    end
  end

  // Shared audio data pin: serial data, or control0 from the carrier bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) audioDataOrControl0 <= 1'b0;
    else if (!audioEnable) begin
      if (decodedWordValid) audioDataOrControl0 <= carrierBit;
    end else audioDataOrControl0 <= (playState_reg == LPM_PLAY) & shift_reg[31];
  end

  // Checks
  property p_three_lane_quiet;
    @(posedge clk) disable iff (!rstn)
    !laneWidthSelect [*2] |-> !fourthLvdsLaneEn && !auxControlOneEn && !auxControlOne;
  endproperty
  a_three_lane_quiet: assert property (p_three_lane_quiet)
    else $error("three-lane mode drives fourth-lane outputs");

  property p_spare_forced;
    @(posedge clk) disable iff (!rstn)
    ##1 ($past(spareLow) && $past(fourLane)) |-> !spareBitOutput;
  endproperty
  a_spare_forced: assert property (p_spare_forced)
    else $error("spare bit not held low");

  property p_ctrl1_follows;
    @(posedge clk) disable iff (!rstn)
    (decodedWordValid && fourLane && !ctrl1Low) |=> auxControlOne == $past(decodedWord[AUX1_POS]);
  endproperty
  a_ctrl1_follows: assert property (p_ctrl1_follows)
    else $error("control1 does not follow bit 27");

  property p_parity_count;
    @(posedge clk) disable iff (!rstn)
    (decodedWordValid && parityBad && parityErrorCount < 8'hFF)
      |=> parityErrorCount == $past(parityErrorCount) + 8'h01;
  endproperty
  a_parity_count: assert property (p_parity_count)
    else $error("parity error not counted");

  property p_payload_map;
    @(posedge clk) disable iff (!rstn)
    (decodedWordValid && !fourLane) |=> lanePayload[27:21] == 7'h00 &&
      lanePayload[20:0] == $past(decodedWord[20:0]);
  endproperty
  a_payload_map: assert property (p_payload_map)
    else $error("three-lane payload mapping wrong");

  property p_ctrl2_pin;
    @(posedge clk) disable iff (!rstn)
    (!mclkActive && fourLane && decodedWordValid) ##1 (!mclkActive && fourLane)
      |-> control2OrAudioClock == $past(decodedWord[AUX2_POS]);
  endproperty
  a_ctrl2_pin: assert property (p_ctrl2_pin)
    else $error("control2 pin not carrying bit 28");

  sequence s_src_high_speed;
    !srcIsOsc && !clockRangeSelect;
  endsequence
  property p_multiple;
    @(posedge clk) disable iff (!rstn)
    s_src_high_speed |=> sourceMultiple == ($past(fourLane) ? MULT_HS_4LANE : MULT_HS_3LANE);
  endproperty
  a_multiple: assert property (p_multiple)
    else $error("divider source multiple wrong");

  sequence s_audio_off_word;
    !audioEnable && decodedWordValid;
  endsequence
  property p_ctrl0_pin;
    @(posedge clk) disable iff (!rstn)
    s_audio_off_word |=> audioDataOrControl0 == $past(carrierBit);
  endproperty
  a_ctrl0_pin: assert property (p_ctrl0_pin)
    else $error("control0 not on shared audio pin");

  property p_no_push_full;
    @(posedge clk) disable iff (!rstn)
    (collectDone && fifoFull) |=> audioOverflow && wrPtr_reg == $past(wrPtr_reg);
  endproperty
  a_no_push_full: assert property (p_no_push_full)
    else $error("audio FIFO written while full");

endmodule

/* File: include/lpm_pkg.sv */
package lpm_pkg;

  // Register map (control-channel register addresses)
  localparam logic [7:0] CLK_DIV_CTRL_ADDR   = 8'h12;
  localparam logic [7:0] OUTPUT_CONFIG_ADDR  = 8'h14;
  localparam logic [7:0] CLK_DIV_CTRL_RESET  = 8'h00;
  localparam logic [7:0] OUTPUT_CONFIG_RESET = 8'h01;

  // Field positions
  localparam int DIV_SRC_BIT     = 7;
  localparam int SPARE_LOW_BIT   = 2;
  localparam int CTRL1_LOW_BIT   = 3;

  // Decoded word layout, three lanes
  localparam int PAYLOAD3_BITS   = 21;
  localparam int CARRIER3_POS    = 21;
  localparam int FWDCTL3_POS     = 22;
  localparam int PARITY3_POS     = 23;

  // Decoded word layout, four lanes
  localparam int PAYLOAD4_BITS   = 28;
  localparam int AUX1_POS        = 27;
  localparam int AUX2_POS        = 28;
  localparam int CARRIER4_POS    = 29;
  localparam int FWDCTL4_POS     = 30;
  localparam int PARITY4_POS     = 31;

  // Divider source multiples of the pixel clock
  localparam logic [3:0] MULT_HS_3LANE = 4'h3;
  localparam logic [3:0] MULT_HS_4LANE = 4'h4;
  localparam logic [3:0] MULT_LS_3LANE = 4'h6;
  localparam logic [3:0] MULT_LS_4LANE = 4'h8;
  localparam logic [3:0] MULT_OSC      = 4'h0;

  // Audio buffer and word length limits
  localparam int         FIFO_DEPTH    = 8;
  localparam int         FIFO_AW       = 3;
  localparam logic [5:0] WORD_LEN_MIN  = 6'h04;
  localparam logic [5:0] WORD_LEN_MAX  = 6'h20;
  localparam logic [15:0] BIT_PERIOD_MIN = 16'h0002;

  // Player states
  typedef enum logic [1:0] {LPM_IDLE, LPM_PLAY} lpm_play_t;

endpackage

/* File: testbench/lpm_link_source.sv */
`timescale 1ns/1ps
module lpm_link_source
  import lpm_pkg::*;
(
  // Clock and lane mode
  input  wire logic        clk,
  input  wire logic        laneWidthSelect,
  // Decoded word toward the mapper
  output logic [31:0]      decodedWord,
  output logic             decodedWordValid
);
  // Quiet bus at time zero
  initial begin
    decodedWord      = 32'h0000_0000;
    decodedWordValid = 1'b0;
  end
  // One recovered, decoded word; parity is even unless broken on purpose
  task automatic send(input logic [28:0] pay, input logic car, input logic fwd, input logic bad);
    logic [31:0] w;
    begin
      w = 32'h0000_0000;
      if (laneWidthSelect) begin
        w[28:0]         = pay;
        w[CARRIER4_POS] = car;
        w[FWDCTL4_POS]  = fwd;
        w[PARITY4_POS]  = ^w[30:0] ^ bad;
      end else begin
        w[20:0]         = pay[20:0];
        w[CARRIER3_POS] = car;
        w[FWDCTL3_POS]  = fwd;
        w[PARITY3_POS]  = ^w[22:0] ^ bad;
      end
      @(posedge clk);
      #1;
      decodedWord      = w;
      decodedWordValid = 1'b1;
      @(posedge clk);
      #1;
      // Released bus shows the inverse, so a stale word cannot pass unseen
      decodedWord      = ~w;
      decodedWordValid = 1'b0;
    end
  endtask
endmodule

/* File: testbench/test_link_payload_output_mapper.sv */
`timescale 1ns/1ps
module test_link_payload_output_mapper;
  import lpm_pkg::*;
  // Stimulus
  logic        clk, nrst, laneWidthSelect, clockRangeSelect, audioEnable;
  logic        pixelSourceTick, oscillatorTick, regWrEn;
  logic [5:0]  audioWordLength;
  logic [7:0]  regAddr, regWrData, rd;
  // Observed outputs
  logic [31:0] decodedWord;
  logic        decodedWordValid;
  logic [7:0]  regRdData, parityErrorCount;
  logic [27:0] lanePayload;
  logic [3:0]  sourceMultiple;
  logic        fourthLvdsLaneEn, clockRangeLow, spareBitOutput, auxControlOne, auxControlOneEn;
  logic        control2OrAudioClock, control2OrAudioClockEn, forwardControlBit;
  logic        audioDataOrControl0, i2sBitClock, i2sWordSelect, audioOverflow;
  int          num_errors, num_checks;

  lpm_payload_mapper dut (.clk(clk), .nrst(nrst), .decodedWord(decodedWord),
    .decodedWordValid(decodedWordValid), .laneWidthSelect(laneWidthSelect),
    .clockRangeSelect(clockRangeSelect), .audioEnable(audioEnable),
    .audioWordLength(audioWordLength), .pixelSourceTick(pixelSourceTick),
    .oscillatorTick(oscillatorTick), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .lanePayload(lanePayload),
    .fourthLvdsLaneEn(fourthLvdsLaneEn), .clockRangeLow(clockRangeLow),
    .sourceMultiple(sourceMultiple), .spareBitOutput(spareBitOutput),
    .auxControlOne(auxControlOne), .auxControlOneEn(auxControlOneEn),
    .control2OrAudioClock(control2OrAudioClock),
    .control2OrAudioClockEn(control2OrAudioClockEn), .forwardControlBit(forwardControlBit),
    .audioDataOrControl0(audioDataOrControl0), .i2sBitClock(i2sBitClock),
    .i2sWordSelect(i2sWordSelect), .parityErrorCount(parityErrorCount),
    .audioOverflow(audioOverflow));
  lpm_link_source src (.clk(clk), .laneWidthSelect(laneWidthSelect),
    .decodedWord(decodedWord), .decodedWordValid(decodedWordValid));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Comparison with mismatch report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    regWrEn = 1'b1; regAddr = a; regWrData = d;
    cyc(1);
    regWrEn = 1'b0;
  endtask
  // Read settles one edge after the address is applied
  task automatic reg_rd(input logic [7:0] a);
    regAddr = a;
    cyc(3);
    rd = regRdData;
  endtask
  task automatic test_reset_and_regs();
    reg_rd(CLK_DIV_CTRL_ADDR); check(rd, 8'h00);
    reg_rd(OUTPUT_CONFIG_ADDR); check(rd, 8'h01);
    check(sourceMultiple, MULT_HS_3LANE);
    reg_wr(OUTPUT_CONFIG_ADDR, 8'h0C); reg_rd(OUTPUT_CONFIG_ADDR); check(rd, 8'h0C);
    // Unmapped place must neither store nor answer
    reg_wr(8'h20, 8'hFF); reg_rd(8'h20); check(rd, 8'h00);
    reg_wr(OUTPUT_CONFIG_ADDR, 8'h01);
  endtask
  task automatic test_three_lane();
    laneWidthSelect = 1'b0;
    src.send(29'h1F5A_5A5A, 1'b0, 1'b1, 1'b0);
    cyc(2);
    check(lanePayload, 28'h01A_5A5A);
    check({fourthLvdsLaneEn, auxControlOneEn, control2OrAudioClockEn}, 3'h0);
    check({spareBitOutput, auxControlOne, control2OrAudioClock}, 3'h0);
    check(forwardControlBit, 1'b1);
  endtask
  task automatic test_four_lane();
    laneWidthSelect = 1'b1;
    src.send(29'h1C3C_A5A5, 1'b0, 1'b0, 1'b0);
    cyc(2);
    check(lanePayload, 28'hC3C_A5A5);
    check({fourthLvdsLaneEn, auxControlOneEn, control2OrAudioClockEn}, 3'h7);
    check({spareBitOutput, auxControlOne, control2OrAudioClock}, 3'h7);
    check(forwardControlBit, 1'b0);
    reg_wr(OUTPUT_CONFIG_ADDR, 8'h0D);
    src.send(29'h1C3C_A5A5, 1'b0, 1'b0, 1'b0);
    cyc(2);
    check({spareBitOutput, auxControlOne, control2OrAudioClock}, 3'h1);
    reg_wr(OUTPUT_CONFIG_ADDR, 8'h01);
  endtask
  task automatic test_parity();
    logic [7:0] c0;
    c0 = parityErrorCount;
    src.send(29'h0123_4567, 1'b1, 1'b0, 1'b1);
    cyc(2);
    check(parityErrorCount, c0 + 8'h01);
    check(lanePayload, 28'h123_4567);
    src.send(29'h0765_4321, 1'b0, 1'b1, 1'b0);
    cyc(2);
    check(parityErrorCount, c0 + 8'h01);
  endtask
  // Every lane, range and source combination
  task automatic test_source_mult();
    logic [3:0] e;
    for (int i = 0; i < 8; i++) begin
      laneWidthSelect = i[0]; clockRangeSelect = i[1];
      reg_wr(CLK_DIV_CTRL_ADDR, {i[2], 7'h00});
      cyc(2);
      e = i[2] ? MULT_OSC : i[1] ? (i[0] ? MULT_LS_4LANE : MULT_LS_3LANE)
                                 : (i[0] ? MULT_HS_4LANE : MULT_HS_3LANE);
      check(sourceMultiple, e);
      check(clockRangeLow, i[1]);
    end
    clockRangeSelect = 1'b0;
    reg_wr(CLK_DIV_CTRL_ADDR, 8'h00);
  endtask
  task automatic test_audio_off();
    audioEnable = 1'b0;
    for (int b = 0; b < 2; b++) begin
      src.send(29'h0000_0000, b[0], 1'b0, 1'b0);
      cyc(2);
      check(audioDataOrControl0, b[0]);
    end
    audioEnable = 1'b1;
  endtask
  // Four-bit words: first word 1011, then an empty buffer plays zeros
  task automatic test_audio();
    logic [7:0] bits;
    logic [7:0] ws;
    int rises;
    logic prev;
    audioWordLength = 6'h04;
    rises = 0;
    bits = 8'h00;
    ws = 8'h00;
    prev = i2sBitClock;
    for (int k = 0; k < 4; k++) src.send(29'h0000_0000, k != 1, 1'b0, 1'b0);
    for (int t = 0; t < 20; t++) begin
      cyc(1);
      if (i2sBitClock === 1'b1 && prev === 1'b0 && rises < 8) begin
        bits = {bits[6:0], audioDataOrControl0};
        ws = {ws[6:0], i2sWordSelect};
        rises++;
      end
      prev = i2sBitClock;
    end
    check(bits, 8'hB0);
    check(ws, 8'h0F);
    check(audioOverflow, 1'b0);
  endtask
  // Divide by four: one rising edge every four source ticks
  task automatic test_divider();
    int rises;
    logic prev;
    laneWidthSelect = 1'b1;
    src.send(29'h0000_0000, 1'b0, 1'b0, 1'b0);
    reg_wr(CLK_DIV_CTRL_ADDR, 8'h04);
    cyc(2);
    rises = 0;
    prev = control2OrAudioClock;
    for (int t = 0; t < 32; t++) begin
      pixelSourceTick = ~t[0];
      cyc(1);
      if (control2OrAudioClock === 1'b1 && prev === 1'b0) rises++;
      prev = control2OrAudioClock;
    end
    pixelSourceTick = 1'b0;
    check(rises, 4);
    reg_wr(CLK_DIV_CTRL_ADDR, 8'h00);
  endtask
  // Watchdog
  initial begin
    #200us;
    num_errors++;
    final_report();
  end
  // Main sequence
  initial begin
    num_errors = 0; num_checks = 0;
    nrst = 1'b0; laneWidthSelect = 1'b0; clockRangeSelect = 1'b0; audioEnable = 1'b1;
    audioWordLength = 6'h10; pixelSourceTick = 1'b0; oscillatorTick = 1'b0;
    regWrEn = 1'b0; regAddr = 8'h00; regWrData = 8'h00;
    cyc(5);
    nrst = 1'b1;
    cyc(4);
    test_reset_and_regs();
    test_three_lane();
    test_four_lane();
    test_parity();
    test_source_mult();
    test_audio_off();
    test_audio();
    test_divider();
    final_report();
  end
endmodule
